// file: include/mcg_pkg.sv
/*
 * Shared constants and types of the motion command gate: register map, field
 * layout, reset values, start latency figures, axis states and command codes.
 * Assumes a single 10 MHz system clock.
 */
package mcg_pkg;

  // ==========================================================================
  // Register map (byte addresses, one aligned 32-bit word each)
  localparam logic [7:0] ADDR_CMD    = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MASK   = 8'h08;
  localparam logic [7:0] ADDR_STATE  = 8'h0C;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Command word fields
  localparam int         CMD_CODE_LSB = 0;
  localparam int         CMD_CODE_W   = 5;
  localparam int         CMD_AXIS_LSB = 8;
  localparam logic [1:0] AXIS_ALL     = 2'h0;
  localparam logic [1:0] AXIS_X       = 2'h1;
  localparam logic [1:0] AXIS_Y       = 2'h2;
  localparam logic [1:0] AXIS_BOTH    = 2'h3;

  // ==========================================================================
  // Event bits of the status and mask registers
  localparam int         EV_ACK = 0;
  localparam int         EV_IGN = 1;
  localparam int         EV_ERR = 2;
  localparam int         EV_SPD = 3;
  localparam int         EV_W   = 4;
  localparam logic [3:0] MASK_RST = 4'h0;

  localparam int NUM_AXES = 2;

  // ==========================================================================
  // Start-to-speed-output latency
  localparam int CLK_HZ        = 10_000_000;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int START_NORM_NS = 6_000_000;
  localparam int START_LONG_NS = 10_000_000;
  localparam int START_NORM_CYC = START_NORM_NS / CLK_PERIOD_NS;
  localparam int START_LONG_CYC = START_LONG_NS / CLK_PERIOD_NS;

  // ==========================================================================
  // Types
  typedef enum logic [3:0] {
    AX_INIT, AX_STOP, AX_POS, AX_ORIGIN, AX_DECEL,
    AX_JOG, AX_INCH, AX_PAUSE, AX_EMERG
  } mcg_axis_st_t;

  typedef enum logic [4:0] {
    end_list_cmd, no_operation_cmd, ext_output_cmd, speed_override_cmd,
    emergency_halt_cmd, error_reset_cmd, pause_cmd, decelerate_halt_cmd,
    resume_cmd, start_positioning_cmd, jog_cmd, inch_cmd, origin_search_cmd,
    clear_all_data_cmd, clear_data_cmd, clear_block_cmd, eeprom_store_cmd,
    eeprom_to_ram_load_cmd, data_read_cmd, transfer_word_cmd, teach_cmd,
    teach_with_fields_cmd, preset_current_position_cmd, home_offset_enable_cmd
  } mcg_cmd_t;

  typedef enum logic [1:0] {RES_ACK, RES_IGN, RES_ERR} mcg_res_t;

endpackage

// file: core/mcg_start_timer.sv
/*
 * Start latency timer of one axis: after a start pulse it raises done for one
 * cycle once the normal or the long latency has elapsed.
 * Assumes start is a single-cycle pulse in the system clock domain; cancel may be held as a level.
 */
`timescale 1ns/1ps
module mcg_start_timer
  import mcg_pkg::*;
#(
  parameter int NORM_CYC = START_NORM_CYC,
  parameter int LONG_CYC = START_LONG_CYC
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic start,
  input  wire logic long_sel,
  input  wire logic cancel,
  output logic      done
);
  localparam int CNT_W = $clog2(LONG_CYC + 1);

  generate
    if (NORM_CYC < 1 || LONG_CYC < NORM_CYC) begin : g_bad
      $error("start latency counts out of range");
    end
  endgenerate

  typedef struct packed {
    logic             run;
    logic             sel;
    logic [CNT_W-1:0] cnt;
    logic             done;
  } mcg_tmr_st_t;

  mcg_tmr_st_t r_reg, r_next;

  always_comb begin
    r_next      = r_reg;
    r_next.done = 1'b0;
    if (start) begin
      r_next.run = 1'b1;
      r_next.sel = long_sel;
      r_next.cnt = long_sel ? CNT_W'(LONG_CYC - 1) : CNT_W'(NORM_CYC - 1);
    end else if (cancel) begin
      r_next.run = 1'b0;
    end else if (r_reg.run) begin
      if (r_reg.cnt == '0) begin
        r_next.run  = 1'b0;
        r_next.done = 1'b1;
      end else begin
        r_next.cnt = r_reg.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign done = r_reg.done;

  // ==========================================================================
  // Checks: edges from start to done
  logic [CNT_W-1:0] elapsed_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      elapsed_reg <= '0;
    end else if (start) begin
      elapsed_reg <= '0;
    end else if (r_reg.run) begin
      elapsed_reg <= elapsed_reg + 1'b1;
    end
  end

  AST_NORMAL_LATENCY:
    assert property (@(posedge clk) disable iff (!rst_n)
      done && !r_reg.sel |-> elapsed_reg == CNT_W'(NORM_CYC))
    else $error("normal start latency wrong");

  AST_LONG_LATENCY:
    assert property (@(posedge clk) disable iff (!rst_n)
      done && r_reg.sel |-> elapsed_reg == CNT_W'(LONG_CYC))
    else $error("long start latency wrong");

endmodule

// file: core/mcg_gate.sv
/*
 * Command acceptance gate of a two-axis position controller with an AXI4-Lite
 * register slave, per-axis motion state and start latency timers.
 * Assumes synchronous inputs and a motion engine that pulses MOTION_DONE.
 */
// Behaviour
// - Ready-only commands ignored while not ready
// - Pause, stop accepted only while operating
// - Resume accepted only while paused
// - Stopped-only commands error in other states, except emergency
// - Speed output about 6 ms after start
// - Latency 10 ms when busy or other moving
// - Stop while paused clears pause, decelerates
// - Parked override applies at next start positioning, not at jog, inch or origin
// - Emergency state ignores motion, accepts data commands
// - Init accepts jog/inch/origin, errors start
// - Pause ignored inching; read always accepted
`timescale 1ns/1ps
module mcg_gate
  import mcg_pkg::*;
#(
  parameter int START_NORM = START_NORM_CYC,
  parameter int START_LONG = START_LONG_CYC
) (
  input  wire logic                SYS_CLK,
  input  wire logic                RSTN,
  input  wire logic [7:0]          S_AXI_AWADDR,
  input  wire logic                S_AXI_AWVALID,
  output logic                     S_AXI_AWREADY,
  input  wire logic [31:0]         S_AXI_WDATA,
  input  wire logic [3:0]          S_AXI_WSTRB,
  input  wire logic                S_AXI_WVALID,
  output logic                     S_AXI_WREADY,
  output logic [1:0]               S_AXI_BRESP,
  output logic                     S_AXI_BVALID,
  input  wire logic                S_AXI_BREADY,
  input  wire logic [7:0]          S_AXI_ARADDR,
  input  wire logic                S_AXI_ARVALID,
  output logic                     S_AXI_ARREADY,
  output logic [31:0]              S_AXI_RDATA,
  output logic [1:0]               S_AXI_RRESP,
  output logic                     S_AXI_RVALID,
  input  wire logic                S_AXI_RREADY,
  input  wire logic [NUM_AXES-1:0] MOTION_DONE,
  input  wire logic                INIT_DONE,
  input  wire logic                BUSY_LONG,
  output logic [NUM_AXES-1:0]      SPEED_EN,
  output logic [NUM_AXES-1:0]      SPEED_OVERRIDE_APPLY,
  output logic                     CMD_READY,
  output logic                     IRQ
);

  typedef struct packed {
    mcg_axis_st_t [NUM_AXES-1:0] ax;
    mcg_axis_st_t [NUM_AXES-1:0] resume_st;
    logic [NUM_AXES-1:0]         override_pend;
    logic [NUM_AXES-1:0]         override_apply;
    logic [NUM_AXES-1:0]         spd_en;
    logic [EV_W-1:0]             status;
    logic [EV_W-1:0]             mask;
    mcg_res_t                    last_res;
    logic                        ready;
    logic                        aw_got;
    logic [7:0]                  awaddr;
    logic                        w_got;
    logic [31:0]                 wdata;
    logic [3:0]                  wstrb;
    logic                        bvalid;
    logic [1:0]                  bresp;
    logic                        rvalid;
    logic [31:0]                 rdata;
    logic [1:0]                  rresp;
  } mcg_gate_st_t;

  mcg_gate_st_t r_reg, r_next;

  logic                wr_fire;
  logic                cmd_fire;
  logic                acc;
  mcg_cmd_t            cmd_code;
  logic [1:0]          axis_f;
  logic [1:0]          tgt;
  mcg_axis_st_t        sel_st;
  mcg_res_t            res;
  logic [NUM_AXES-1:0] start_ev;
  logic [NUM_AXES-1:0] long_sel;
  logic [NUM_AXES-1:0] tm_cancel;
  logic [NUM_AXES-1:0] tm_done;

  // ==========================================================================
  // Helpers
  function automatic logic moving(input mcg_axis_st_t s);
    return !(s == AX_STOP || s == AX_EMERG || s == AX_INIT);
  endfunction

  // Interpolation sees the most restrictive view of both axes
  function automatic mcg_axis_st_t comb_st(input mcg_axis_st_t a, input mcg_axis_st_t b);
    if (a == AX_EMERG || b == AX_EMERG) begin
      return AX_EMERG;
    end else if (a == AX_INIT || b == AX_INIT) begin
      return AX_INIT;
    end else if (a == AX_PAUSE || b == AX_PAUSE) begin
      return AX_PAUSE;
    end else if (a != AX_STOP) begin
      return a;
    end
    return b;
  endfunction

  function automatic mcg_res_t classify(input mcg_cmd_t c, input mcg_axis_st_t s,
                                        input logic rdy);
    mcg_res_t v;
    v = RES_ERR;
    case (c)
      end_list_cmd, no_operation_cmd, ext_output_cmd, speed_override_cmd,
      error_reset_cmd: begin
        v = rdy ? RES_ACK : RES_IGN;
      end
      emergency_halt_cmd: begin
        v = (rdy && s != AX_EMERG) ? RES_ACK : RES_IGN;
      end
      pause_cmd: begin
        v = (!moving(s) || s == AX_INCH) ? RES_IGN : RES_ACK;
      end
      decelerate_halt_cmd: begin
        v = moving(s) ? RES_ACK : RES_IGN;
      end
      resume_cmd: begin
        v = (s == AX_PAUSE) ? RES_ACK : RES_IGN;
      end
      data_read_cmd: begin
        v = RES_ACK;
      end
      start_positioning_cmd: begin
        v = (s == AX_STOP) ? RES_ACK : (s == AX_EMERG) ? RES_IGN : RES_ERR;
      end
      jog_cmd, inch_cmd, origin_search_cmd, preset_current_position_cmd: begin
        v = (s == AX_STOP || s == AX_INIT) ? RES_ACK
          : (s == AX_EMERG) ? RES_IGN : RES_ERR;
      end
      clear_all_data_cmd, clear_data_cmd, clear_block_cmd, eeprom_store_cmd,
      eeprom_to_ram_load_cmd, transfer_word_cmd, teach_cmd, teach_with_fields_cmd,
      home_offset_enable_cmd: begin
        v = moving(s) ? RES_ERR : RES_ACK;
      end
      default: begin
        v = RES_ERR;
      end
    endcase
    return v;
  endfunction

  // ==========================================================================
  // Command decode
  assign wr_fire  = r_reg.aw_got && r_reg.w_got && !r_reg.bvalid;
  assign cmd_fire = wr_fire && r_reg.awaddr == ADDR_CMD && r_reg.wstrb[0];
  assign cmd_code = mcg_cmd_t'(r_reg.wdata[CMD_CODE_LSB +: CMD_CODE_W]);
  assign axis_f   = r_reg.wdata[CMD_AXIS_LSB +: 2];
  assign tgt      = (axis_f == AXIS_ALL) ? AXIS_BOTH : axis_f;
  assign sel_st   = (tgt == AXIS_BOTH) ? comb_st(r_reg.ax[0], r_reg.ax[1])
                                       : r_reg.ax[tgt[1]];
  assign res      = classify(cmd_code, sel_st, r_reg.ready);
  assign acc      = cmd_fire && res == RES_ACK;

  // ==========================================================================
  // Next state
  always_comb begin
    logic [EV_W-1:0] ev_set;
    logic [EV_W-1:0] ev_wipe;
    r_next                = r_reg;
    r_next.override_apply = '0;
    start_ev              = '0;
    long_sel              = '0;
    tm_cancel             = '0;
    ev_set                = '0;
    ev_wipe               = '0;
    r_next.ready          = !BUSY_LONG;

    for (int i = 0; i < NUM_AXES; i++) begin
      if (MOTION_DONE[i] && moving(r_reg.ax[i]) && r_reg.ax[i] != AX_PAUSE) begin
        r_next.ax[i] = AX_STOP;
      end
      if (r_reg.ax[i] == AX_INIT && INIT_DONE) begin
        r_next.ax[i] = AX_STOP;
      end
      if (acc && tgt[i]) begin
        case (cmd_code)
          start_positioning_cmd: begin
            r_next.ax[i] = AX_POS;
            if (r_reg.override_pend[i]) begin
              r_next.override_apply[i] = 1'b1;
              r_next.override_pend[i]  = 1'b0;
            end
          end
          jog_cmd: begin
            r_next.ax[i] = AX_JOG;
          end
          inch_cmd: begin
            r_next.ax[i] = AX_INCH;
          end
          origin_search_cmd: begin
            r_next.ax[i] = AX_ORIGIN;
          end
          decelerate_halt_cmd: begin
            if (moving(r_reg.ax[i])) begin
              r_next.ax[i] = AX_DECEL;
            end
          end
          pause_cmd: begin
            if (moving(r_reg.ax[i]) && r_reg.ax[i] != AX_INCH && r_reg.ax[i] != AX_PAUSE) begin
              r_next.resume_st[i] = r_reg.ax[i];
              r_next.ax[i]        = AX_PAUSE;
            end
          end
          resume_cmd: begin
            if (r_reg.ax[i] == AX_PAUSE) begin
              r_next.ax[i] = r_reg.resume_st[i];
            end
          end
          emergency_halt_cmd: begin
            r_next.ax[i] = AX_EMERG;
          end
          speed_override_cmd: begin
            if (r_reg.ax[i] == AX_POS || r_reg.ax[i] == AX_ORIGIN || r_reg.ax[i] == AX_JOG) begin
              r_next.override_apply[i] = 1'b1;
            end else begin
              r_next.override_pend[i] = 1'b1;
            end
          end
          error_reset_cmd: begin
            if (r_reg.ax[i] == AX_EMERG) begin
              r_next.ax[i] = AX_STOP;
            end
          end
          default: begin
          end
        endcase
        start_ev[i] = cmd_code == start_positioning_cmd || cmd_code == jog_cmd
                   || cmd_code == inch_cmd || cmd_code == origin_search_cmd;
      end
      // other axis moving or lengthy work
      long_sel[i]  = BUSY_LONG || moving(r_reg.ax[NUM_AXES-1-i]);
      tm_cancel[i] = !moving(r_next.ax[i]);
      if (tm_done[i] && moving(r_next.ax[i])) begin
        r_next.spd_en[i] = 1'b1;
        ev_set[EV_SPD]   = 1'b1;
      end
      if (!moving(r_next.ax[i])) begin
        r_next.spd_en[i] = 1'b0;
      end
    end

    // Register writes, taken once both halves have arrived
    if (wr_fire) begin
      r_next.aw_got = 1'b0;
      r_next.w_got  = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp  = RESP_OKAY;
      if (r_reg.awaddr == ADDR_CMD) begin
        if (cmd_fire) begin
          r_next.last_res                    = res;
          ev_set[EV_ACK + int'(res)]         = 1'b1;
        end
      end else if (r_reg.awaddr == ADDR_STATUS) begin
        if (r_reg.wstrb[0]) begin
          ev_wipe = r_reg.wdata[EV_W-1:0];
        end
      end else if (r_reg.awaddr == ADDR_MASK) begin
        if (r_reg.wstrb[0]) begin
          r_next.mask = r_reg.wdata[EV_W-1:0];
        end
      end else if (r_reg.awaddr != ADDR_STATE) begin
        r_next.bresp = RESP_SLVERR;
      end
    end
    // A new event wins over a simultaneous write-one-to-clear
    r_next.status = (r_reg.status & ~ev_wipe) | ev_set;

    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      r_next.aw_got = 1'b1;
      r_next.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      r_next.w_got = 1'b1;
      r_next.wdata = S_AXI_WDATA;
      r_next.wstrb = S_AXI_WSTRB;
    end
    if (r_reg.bvalid && S_AXI_BREADY) begin
      r_next.bvalid = 1'b0;
    end

    if (r_reg.rvalid && S_AXI_RREADY) begin
      r_next.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      r_next.rvalid = 1'b1;
      r_next.rresp  = RESP_OKAY;
      r_next.rdata  = '0;
      if (S_AXI_ARADDR == ADDR_STATUS) begin
        r_next.rdata[EV_W-1:0] = r_reg.status;
      end else if (S_AXI_ARADDR == ADDR_MASK) begin
        r_next.rdata[EV_W-1:0] = r_reg.mask;
      end else if (S_AXI_ARADDR == ADDR_STATE) begin
        r_next.rdata = {14'h0000, r_reg.last_res, 2'h0, r_reg.spd_en, 1'h0,
                        r_reg.override_pend, r_reg.ready, r_reg.ax[1], r_reg.ax[0]};
      end else if (S_AXI_ARADDR != ADDR_CMD) begin
        r_next.rresp = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      r_reg      <= '0;
      r_reg.ax   <= {AX_INIT, AX_INIT};
      r_reg.mask <= MASK_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================================
  // Start latency timers
  generate
    for (genvar g = 0; g < NUM_AXES; g++) begin : g_axis
      mcg_start_timer #(
        .NORM_CYC (START_NORM),
        .LONG_CYC (START_LONG)
      ) u_timer (
        .clk      (SYS_CLK),
        .rst_n    (RSTN),
        .start    (start_ev[g]),
        .long_sel (long_sel[g]),
        .cancel   (tm_cancel[g]),
        .done     (tm_done[g])
      );
    end
  endgenerate

  assign S_AXI_AWREADY        = !r_reg.aw_got && !r_reg.bvalid;
  assign S_AXI_WREADY         = !r_reg.w_got && !r_reg.bvalid;
  assign S_AXI_BVALID         = r_reg.bvalid;
  assign S_AXI_BRESP          = r_reg.bresp;
  assign S_AXI_ARREADY        = !r_reg.rvalid;
  assign S_AXI_RVALID         = r_reg.rvalid;
  assign S_AXI_RDATA          = r_reg.rdata;
  assign S_AXI_RRESP          = r_reg.rresp;
  assign SPEED_EN             = r_reg.spd_en;
  assign SPEED_OVERRIDE_APPLY = r_reg.override_apply;
  assign CMD_READY            = r_reg.ready;
  assign IRQ                  = |(r_reg.status & r_reg.mask);

  // ==========================================================================
  // Checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);

  sequence s_cmd_x(mcg_cmd_t c, mcg_axis_st_t s);
    cmd_fire && cmd_code == c && tgt == AXIS_X && r_reg.ax[0] == s;
  endsequence

  AST_NOT_READY_IGNORED:
    assert property (cmd_fire && !r_reg.ready && cmd_code == no_operation_cmd
      |=> r_reg.status[EV_IGN] && r_reg.last_res == RES_IGN)
    else $error("command taken while not ready");
  AST_STOP_IDLE_IGNORED:
    assert property (s_cmd_x(decelerate_halt_cmd, AX_STOP) ##0 !MOTION_DONE[0]
      |=> r_reg.ax[0] == AX_STOP && r_reg.last_res == RES_IGN)
    else $error("stop taken while idle");
  AST_RESUME_NEEDS_PAUSE:
    assert property (s_cmd_x(resume_cmd, AX_JOG) ##0 !MOTION_DONE[0]
      |=> r_reg.ax[0] == AX_JOG ##0 r_reg.status[EV_IGN])
    else $error("resume taken without pause");
  AST_START_MOVING_ERRORS:
    assert property (s_cmd_x(start_positioning_cmd, AX_POS)
      |=> r_reg.status[EV_ERR] && r_reg.last_res == RES_ERR)
    else $error("start while moving gave no error");
  AST_STOP_CLEARS_PAUSE:
    assert property (s_cmd_x(decelerate_halt_cmd, AX_PAUSE) |=> r_reg.ax[0] == AX_DECEL)
    else $error("stop did not clear pause");
  AST_OVERRIDE_PARKED:
    assert property (s_cmd_x(speed_override_cmd, AX_STOP) ##0 r_reg.ready
      |=> r_reg.override_pend[0] && !SPEED_OVERRIDE_APPLY[0])
    else $error("override applied while stopped");
  AST_OVERRIDE_AT_START:
    assert property (s_cmd_x(start_positioning_cmd, AX_STOP) ##0 r_reg.override_pend[0]
      |=> SPEED_OVERRIDE_APPLY[0] ##1 !SPEED_OVERRIDE_APPLY[0])
    else $error("parked override not applied");
  AST_EMERG_IGNORES_START:
    assert property (s_cmd_x(start_positioning_cmd, AX_EMERG)
      |=> r_reg.ax[0] == AX_EMERG && r_reg.last_res == RES_IGN)
    else $error("start taken in emergency");
  AST_INIT_JOG_START:
    assert property (s_cmd_x(jog_cmd, AX_INIT) |=> r_reg.ax[0] == AX_JOG)
    else $error("jog refused during init");
  AST_INCH_PAUSE_IGNORED:
    assert property (s_cmd_x(pause_cmd, AX_INCH) ##0 !MOTION_DONE[0]
      |=> r_reg.ax[0] == AX_INCH)
    else $error("pause taken while inching");
  AST_AXIS_ISOLATION:
    assert property (s_cmd_x(start_positioning_cmd, AX_STOP) ##0 (!MOTION_DONE[1]
      && r_reg.ax[1] != AX_INIT) |=> $stable(r_reg.ax[1]))
    else $error("X command moved Y axis");

endmodule

// file: verif/mcg_motion_model.sv
/*
 * Motion engine stand-in: finishes moves and ends power-on init on request.
 * Assumes requests come from the bench in the SYS_CLK domain.
 */
`timescale 1ns/1ps
module mcg_motion_model
  import mcg_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic [NUM_AXES-1:0] fin_req,
  input  wire logic                boot_req,
  output logic      [NUM_AXES-1:0] done_pulse,
  output logic                     boot_done
);
  // Pulse only on a new request, so a held request cannot end a later move
  logic [NUM_AXES-1:0] fin_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {fin_q, done_pulse, boot_done} <= '0;
    end else begin
      fin_q <= fin_req;
      done_pulse <= fin_req & ~fin_q;
      boot_done <= boot_req;
    end
  end
endmodule

// file: verif/tb_top.sv
/*
 * Self-checking bench of the command gate: AXI4-Lite tasks and command tests.
 * Assumes short start latencies of 8 and 12 cycles.
 */
`timescale 1ns/1ps
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin fails++; \
  $display("BAD %s exp %0h got %0h", n, e, a); end end
module tb_top;
  import mcg_pkg::*;
  logic clk = 0, rstn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, boot = 0, busy = 0;
  logic [7:0]  awa = 0, ara = 0;
  logic [31:0] wd = 0, d, rdat;
  logic [1:0]  fin = 0, oseen = 0, r, b, mdone, spd, rresp, bresp, oapp;
  logic        awr, wr, bv, arr, rv, crdy, irq, idone;
  int          fails = 0, comparisons = 0, cyc = 0;
  mcg_motion_model pm (.clk(clk), .rst_n(rstn), .fin_req(fin), .boot_req(boot),
    .done_pulse(mdone), .boot_done(idone));
  mcg_gate #(.START_NORM(8), .START_LONG(12)) uut (.SYS_CLK(clk), .RSTN(rstn),
    .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rry), .MOTION_DONE(mdone), .INIT_DONE(idone), .BUSY_LONG(busy),
    .SPEED_EN(spd), .SPEED_OVERRIDE_APPLY(oapp), .CMD_READY(crdy), .IRQ(irq));
  always #50 clk = ~clk;
  // Apply is a one-cycle pulse, so keep a sticky copy for the tests to read
  always @(posedge clk) oseen <= oseen | oapp;
  // ==========================================================================
  // Bus tasks
  task axw(input logic [7:0] a, input logic [31:0] v);
    logic ad, dd;
    @(posedge clk);
    awa <= a;
    wd <= v;
    {awv, wv, bry} <= 3'h7;
    {ad, dd} = 2'h0;
    while (!(ad && dd)) begin
      @(posedge clk);
      if (awr && !ad) begin
        ad = 1'h1;
        awv <= 1'h0;
      end
      if (wr && !dd) begin
        dd = 1'h1;
        wv <= 1'h0;
      end
    end
    while (!bv) @(posedge clk);
    b = bresp;
    bry <= 1'h0;
  endtask
  task axr(input logic [7:0] a);
    @(posedge clk);
    ara <= a;
    {arv, rry} <= 2'h3;
    do @(posedge clk); while (!arr);
    arv <= 1'h0;
    while (!rv) @(posedge clk);
    d = rdat;
    r = rresp;
    rry <= 1'h0;
  endtask
  task cmd(input mcg_cmd_t c, input logic [1:0] ax, input mcg_res_t e);
    axw(ADDR_CMD, {22'h0, ax, 3'h0, c});
    axr(ADDR_STATE);
    `CHK(c.name(), e, d[17:16])
  endtask
  task tally_and_finish;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Generous ceiling; the tests need well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      tally_and_finish();
    end
  end
  // ==========================================================================
  // Tests
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'h1;
    axr(ADDR_MASK);
    `CHK("mask", 32'h0000_0000, d)
    cmd(pause_cmd, AXIS_X, RES_IGN);
    cmd(start_positioning_cmd, AXIS_X, RES_ERR);
    cmd(data_read_cmd, AXIS_X, RES_ACK);
    cmd(jog_cmd, AXIS_X, RES_ACK);
    cmd(resume_cmd, AXIS_X, RES_IGN);
    cmd(decelerate_halt_cmd, AXIS_X, RES_ACK);
    fin <= 2'h1;
    repeat (2) @(posedge clk);
    fin <= 2'h0;
    $display("end: init");
    boot <= 1'h1;
    cmd(pause_cmd, AXIS_X, RES_IGN);
    cmd(decelerate_halt_cmd, AXIS_X, RES_IGN);
    cmd(resume_cmd, AXIS_X, RES_IGN);
    cmd(speed_override_cmd, AXIS_X, RES_ACK);
    `CHK("pend", 1'h1, d[9])
    cmd(start_positioning_cmd, AXIS_X, RES_ACK);
    `CHK("applied", 2'h1, oseen)
    `CHK("spd_early", 1'h0, spd[0])
    repeat (6) @(posedge clk);
    `CHK("spd_on", 1'h1, spd[0])
    cmd(start_positioning_cmd, AXIS_X, RES_ERR);
    `CHK("pend_used", 1'h0, d[9])
    cmd(clear_data_cmd, AXIS_X, RES_ERR);
    cmd(pause_cmd, AXIS_X, RES_ACK);
    cmd(resume_cmd, AXIS_X, RES_ACK);
    cmd(pause_cmd, AXIS_X, RES_ACK);
    cmd(decelerate_halt_cmd, AXIS_X, RES_ACK);
    `CHK("x_decel", 4'h4, d[3:0])
    fin <= 2'h1;
    repeat (2) @(posedge clk);
    axr(ADDR_STATE);
    `CHK("x_stop", 4'h1, d[3:0])
    $display("end: motion");
    cmd(emergency_halt_cmd, AXIS_X, RES_ACK);
    cmd(start_positioning_cmd, AXIS_X, RES_IGN);
    cmd(preset_current_position_cmd, AXIS_X, RES_IGN);
    cmd(emergency_halt_cmd, AXIS_X, RES_IGN);
    cmd(clear_all_data_cmd, AXIS_X, RES_ACK);
    cmd(data_read_cmd, AXIS_X, RES_ACK);
    cmd(error_reset_cmd, AXIS_ALL, RES_ACK);
    busy <= 1'h1;
    cmd(no_operation_cmd, AXIS_ALL, RES_IGN);
    `CHK("ready", 1'h0, crdy)
    busy <= 1'h0;
    $display("end: emergency");
    cmd(inch_cmd, AXIS_X, RES_ACK);
    cmd(pause_cmd, AXIS_X, RES_IGN);
    cmd(start_positioning_cmd, AXIS_Y, RES_ACK);
    repeat (6) @(posedge clk);
    `CHK("spd_y_late", 1'h0, spd[1])
    repeat (4) @(posedge clk);
    `CHK("spd_y_on", 1'h1, spd[1])
    $display("end: two axes");
    axw(ADDR_STATUS, 32'h0000_000F);
    axw(ADDR_MASK, 32'h0000_0004);
    `CHK("wr_okay", RESP_OKAY, b)
    `CHK("irq_idle", 1'h0, irq)
    cmd(start_positioning_cmd, AXIS_X, RES_ERR);
    `CHK("irq_on", 1'h1, irq)
    axw(ADDR_STATUS, 32'h0000_0004);
    `CHK("irq_off", 1'h0, irq)
    axr(8'h10);
    `CHK("unmapped", RESP_SLVERR, r)
    axw(8'h10, 32'h0000_0000);
    `CHK("wr_unmapped", RESP_SLVERR, b)
    $display("end: registers");
    tally_and_finish();
  end
endmodule
